// ==== include/phy_clk_pkg.sv ====
// constants for the mac-side clocking block of the transceiver
package phy_clk_pkg;
  // system clock rate
  localparam int CLK_HZ = 10_000_000;
  // mii clock rates, with or without link
  localparam int MII10_HZ = 2_500_000;
  localparam int MII100_HZ = 25_000_000;
  // half periods in system clocks, at least one cycle
  localparam int HALF10_CYC = (CLK_HZ / MII10_HZ) / 2 < 1 ? 1 :
    (CLK_HZ / MII10_HZ) / 2;
  localparam int HALF100_CYC = 1;
  localparam logic [3:0] HALF10 = 4'(HALF10_CYC);
  localparam logic [3:0] HALF100 = 4'(HALF100_CYC);
  // management clock ceiling
  localparam int MGMT_MAX_HZ = 2_500_000;
  // management frame fields
  localparam logic [5:0] PREAMBLE_BITS = 6'h20;
  localparam logic [4:0] ADDR_BITS = 5'h05;
  localparam logic [4:0] DATA_BITS = 5'h10;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  // register map
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_TEST = 5'h10;
  localparam int CTRL_LOOP_BIT = 14;
  localparam int TEST_GEN_BIT = 0;
  localparam int TEST_MODE_LSB = 1;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] TEST_RST = 16'h0000;
  localparam logic [2:0] TMODE_2 = 3'h2;
  localparam logic [2:0] TMODE_3 = 3'h3;
  localparam int TMODE_OUT_BIT = 4;
  // speeds
  typedef enum logic [1:0] {SPD_10, SPD_100, SPD_1000} speed_t;
  // generator packet
  localparam logic [7:0] GEN_LEN = 8'h40;
  localparam logic [7:0] GEN_GAP = 8'h0C;
endpackage

// ==== verilog/mii_clk_gen.sv ====
`timescale 1ns/1ps
// divider for the 10/100 transmit and receive clock
module mii_clk_gen (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // control
  input wire logic run,
  input wire logic [3:0] half,
  // clock out
  output logic clk_out,
  output logic rise
);
  import phy_clk_pkg::*;
  typedef struct packed {
    logic [3:0] cnt;
    logic clk;
  } gen_t;
  gen_t st_ff, nxt_st;
  // toggle every half period; held low when stopped
  always_comb begin
    nxt_st = st_ff;
    if (!run) begin
      nxt_st = '0;
    end else if (st_ff.cnt + 4'h1 >= half) begin
      nxt_st.cnt = 4'h0;
      nxt_st.clk = ~st_ff.clk;
    end else begin
      nxt_st.cnt = st_ff.cnt + 4'h1;
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign clk_out = st_ff.clk;
  assign rise = nxt_st.clk & ~st_ff.clk;
endmodule

// ==== verilog/mgmt_slave.sv ====
`timescale 1ns/1ps
// serial management slave with control and test registers
module mgmt_slave (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // management pins, sampled synchronous
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  // address strap
  input wire logic [4:0] phy_addr,
  // register values
  output logic [15:0] ctrl_reg,
  output logic [15:0] test_reg,
  input wire logic [15:0] status_word
);
  import phy_clk_pkg::*;
  typedef enum logic [2:0] {S_PRE, S_ST, S_HDR, S_TA, S_DATA} ph_t;
  typedef struct packed {
    ph_t ph;
    logic [5:0] cnt;
    logic [13:0] hdr;
    logic [15:0] sh;
    logic rd;
    logic oe;
    logic mdc_d;
    logic [15:0] ctrl;
    logic [15:0] test;
  } ms_t;
  ms_t st_ff, nxt_st;
  logic rise, fall;
  assign rise = mdc & ~st_ff.mdc_d;
  assign fall = ~mdc & st_ff.mdc_d;
  function automatic logic [15:0] rd_val(input logic [4:0] a,
    input logic [15:0] c, input logic [15:0] t, input logic [15:0] s);
    rd_val = a == REG_CTRL ? c : a == REG_TEST ? t : s;
  endfunction
  // clause 22 framing on mdc edges
  always_comb begin
    nxt_st = st_ff;
    nxt_st.mdc_d = mdc;
    if (rise) begin
      unique case (st_ff.ph)
        S_PRE: begin
          nxt_st.cnt = mdio_in ? (st_ff.cnt == PREAMBLE_BITS ?
            st_ff.cnt : st_ff.cnt + 6'h01) : 6'h00;
          if (!mdio_in && st_ff.cnt == PREAMBLE_BITS) begin
            nxt_st.ph = S_ST;
          end
        end
        S_ST: begin
          nxt_st.ph = mdio_in ? S_HDR : S_PRE;
          nxt_st.cnt = 6'h00;
        end
        S_HDR: begin
          nxt_st.hdr = {st_ff.hdr[12:0], mdio_in};
          nxt_st.cnt = st_ff.cnt + 6'h01;
          if (st_ff.cnt == 6'(2 + 2 * ADDR_BITS - 1)) begin
            nxt_st.ph = S_TA;
            nxt_st.cnt = 6'h00;
            // address compared here, not in a net, to keep the loop open
            nxt_st.rd = nxt_st.hdr[11:10] == OP_READ &&
              nxt_st.hdr[9:5] == phy_addr;
            nxt_st.sh = rd_val(nxt_st.hdr[4:0], st_ff.ctrl, st_ff.test,
              status_word);
          end
        end
        S_TA: begin
          nxt_st.cnt = st_ff.cnt + 6'h01;
          if (st_ff.cnt == 6'h01) begin
            nxt_st.ph = S_DATA;
            nxt_st.cnt = 6'h00;
          end
        end
        S_DATA: begin
          nxt_st.cnt = st_ff.cnt + 6'h01;
          if (!st_ff.rd) begin
            nxt_st.sh = {st_ff.sh[14:0], mdio_in};
          end
          if (st_ff.cnt == 6'(DATA_BITS - 1)) begin
            nxt_st.ph = S_PRE;
            nxt_st.cnt = 6'h00;
            if (st_ff.hdr[11:10] == OP_WRITE && st_ff.hdr[9:5] == phy_addr)
            begin
              if (st_ff.hdr[4:0] == REG_CTRL) nxt_st.ctrl = nxt_st.sh;
              if (st_ff.hdr[4:0] == REG_TEST) nxt_st.test = nxt_st.sh;
            end
          end
        end
      endcase
    end
    // read data changes after falling edge, released after last bit
    if (fall) begin
      if (st_ff.ph == S_TA && st_ff.cnt == 6'h01 && st_ff.rd) begin
        nxt_st.oe = 1'b1;
      end else if (st_ff.ph == S_DATA && st_ff.rd && st_ff.cnt != 6'h00)
      begin
        nxt_st.sh = {st_ff.sh[14:0], 1'b0};
      end else if (st_ff.ph != S_DATA) begin
        nxt_st.oe = 1'b0;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_ff <= '0;
      st_ff.ctrl <= CTRL_RST;
      st_ff.test <= TEST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign mdio_out = st_ff.oe & st_ff.sh[15];
  assign mdio_oe = st_ff.oe;
  assign ctrl_reg = st_ff.ctrl;
  assign test_reg = st_ff.test;
endmodule

// ==== verilog/phy_mac_side_clocking.sv ====
`timescale 1ns/1ps
// mac-side clocking, loopback and packet generator of the transceiver
// Function
// - start from strap configuration only
// - link comes up without mac or management
// - control bit 14 loops transmit into receive
// - test registers start packet generator toward partner
// - 10/100 device sources transmit clock
// - 1000 mac gigabit clock only captures data
// - master uses reference, slave recovered clock
// - line transmit clock on test pin, at gigabit only
// - unused clock and upper receive lines low
// - activity output on good receive
// - idle mii clocks 2.5 or 5 MHz
module phy_mac_side_clocking (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // straps
  input wire phy_clk_pkg::speed_t strap_speed,
  input wire logic strap_master,
  input wire logic [4:0] strap_addr,
  // line side status and clocks, synchronous
  input wire logic link_ok,
  input wire logic ref_line_clk,
  input wire logic rec_line_clk,
  input wire logic line_rx_dv,
  input wire logic line_rx_err,
  input wire logic [7:0] line_rxd,
  // mac transmit
  input wire logic gtx_clk,
  input wire logic tx_en,
  input wire logic [7:0] txd,
  output logic tx_clk,
  // mac receive
  output logic rx_clk,
  output logic rx_dv,
  output logic [7:0] rxd,
  // line transmit
  output logic line_tx_en,
  output logic [7:0] line_txd,
  output logic line_tx_clk_sel,
  // test and leds
  output logic line_transmit_test_clock,
  output logic activity,
  // management
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe
);
  import phy_clk_pkg::*;
  typedef struct packed {
    speed_t spd;
    logic master;
    logic [4:0] addr;
    logic gtx_d;
    logic tx_en_c;
    logic [7:0] txd_c;
    logic ltx_en;
    logic [7:0] ltxd;
    logic rdv;
    logic [7:0] rd;
    logic act;
    logic [7:0] gcnt;
    logic gbusy;
  } top_t;
  top_t st_ff, nxt_st;
  logic [15:0] ctrl_reg, test_reg;
  logic mii_clk, mii_rise, gig, loop_on, gen_on, gtx_rise, cap, tmode_out;
  logic [2:0] tmode;

  assign gig = st_ff.spd == SPD_1000;
  assign loop_on = ctrl_reg[CTRL_LOOP_BIT];
  assign gen_on = test_reg[TEST_GEN_BIT];
  assign tmode = test_reg[TEST_MODE_LSB +: 3];
  assign tmode_out = test_reg[TMODE_OUT_BIT];
  assign gtx_rise = gtx_clk & ~st_ff.gtx_d;
  // capture edge: own clock at 10/100, mac clock at 1000
  assign cap = gig ? gtx_rise : mii_rise;

  // mii clock runs whenever not gigabit, link state does not gate it
  mii_clk_gen u_clk (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .run(!gig && !sys_rst),
    .half(st_ff.spd == SPD_10 ? HALF10 : HALF100),
    .clk_out(mii_clk),
    .rise(mii_rise)
  );

  mgmt_slave u_mgmt (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .mdc(mdc),
    .mdio_in(mdio_in),
    .mdio_out(mdio_out),
    .mdio_oe(mdio_oe),
    .phy_addr(st_ff.addr),
    .ctrl_reg(ctrl_reg),
    .test_reg(test_reg),
    .status_word({13'h0000, link_ok, st_ff.master, gig})
  );

  // datapath: capture, loopback, generator, receive, activity
  always_comb begin
    nxt_st = st_ff;
    nxt_st.gtx_d = gtx_clk;
    if (cap) begin
      nxt_st.tx_en_c = tx_en;
      nxt_st.txd_c = gig ? txd : {4'h0, txd[3:0]};
    end
    // generator sends a fixed pattern then a gap, no mac needed
    if (gen_on && link_ok) begin
      nxt_st.gcnt = st_ff.gcnt + 8'h01;
      if (st_ff.gbusy && st_ff.gcnt == GEN_LEN) begin
        nxt_st.gbusy = 1'b0;
        nxt_st.gcnt = 8'h00;
      end else if (!st_ff.gbusy && st_ff.gcnt == GEN_GAP) begin
        nxt_st.gbusy = 1'b1;
        nxt_st.gcnt = 8'h00;
      end
    end else begin
      nxt_st.gbusy = 1'b0;
      nxt_st.gcnt = 8'h00;
    end
    // line transmit: loopback keeps the wire quiet
    if (loop_on) begin
      nxt_st.ltx_en = 1'b0;
      nxt_st.ltxd = 8'h00;
    end else if (gen_on) begin
      nxt_st.ltx_en = st_ff.gbusy;
      nxt_st.ltxd = st_ff.gbusy ? st_ff.gcnt : 8'h00;
    end else begin
      nxt_st.ltx_en = st_ff.tx_en_c && link_ok;
      nxt_st.ltxd = st_ff.txd_c;
    end
    // receive path, loopback returns captured transmit data
    if (loop_on) begin
      nxt_st.rdv = st_ff.tx_en_c;
      nxt_st.rd = st_ff.txd_c;
    end else begin
      nxt_st.rdv = line_rx_dv && link_ok;
      nxt_st.rd = line_rxd;
    end
    if (!gig) begin
      nxt_st.rd[7:4] = 4'h0;
    end
    nxt_st.act = line_rx_dv && !line_rx_err && link_ok;
  end

  // straps taken once, in reset, so no register access is needed
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_ff <= '0;
      st_ff.spd <= strap_speed;
      st_ff.master <= strap_master;
      st_ff.addr <= strap_addr;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // line timing selection: reference for master, recovered for slave
  assign line_tx_clk_sel = st_ff.master;
  assign line_transmit_test_clock = gig && (tmode == TMODE_2 ||
    tmode == TMODE_3 || tmode_out) &&
    (st_ff.master ? ref_line_clk : rec_line_clk);
  assign tx_clk = gig ? 1'b0 : mii_clk;
  assign rx_clk = gig ? (st_ff.master ? ref_line_clk : rec_line_clk)
    : mii_clk;
  assign rx_dv = st_ff.rdv;
  assign rxd = st_ff.rd;
  assign line_tx_en = st_ff.ltx_en;
  assign line_txd = st_ff.ltxd;
  assign activity = st_ff.act;

  // gigabit transmit clock stays low
  gig_txclk_low_a: assert property (@(posedge mclk) disable iff (sys_rst)
    gig |-> !tx_clk) else $error("tx clock not low at gigabit");
  upper_rx_low_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !gig |-> rxd[7:4] == 4'h0) else $error("upper rxd not low");
  loop_return_a: assert property (@(posedge mclk) disable iff (sys_rst)
    loop_on && $stable(loop_on) |=> rx_dv == $past(st_ff.tx_en_c))
    else $error("loopback data lost");
  activity_good_a: assert property (@(posedge mclk) disable iff (sys_rst)
    line_rx_dv && !line_rx_err && link_ok |=> activity)
    else $error("activity missing");
  test_clock_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !gig |-> !line_transmit_test_clock)
    else $error("test clock outside gigabit");
  mii_toggle_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !gig && $stable(st_ff.spd) && st_ff.spd == SPD_10 && $rose(mii_clk)
    |=> mii_clk [*1] ##1 !mii_clk) else $error("10 mb clock rate");
  gen_idle_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !gen_on && !loop_on |=> line_tx_en == ($past(st_ff.tx_en_c) &&
    $past(link_ok))) else $error("line enable wrong");
  slave_sel_a: assert property (@(posedge mclk) disable iff (sys_rst)
    line_tx_clk_sel == st_ff.master) else $error("clock select");

  // straps land in the state on the last reset edge
  strap_speed_a: assert property (@(posedge mclk)
    disable iff (sys_rst)
    $past(sys_rst) |-> st_ff.spd == $past(strap_speed))
    else $error("speed strap not taken");
  strap_role_a: assert property (@(posedge mclk)
    disable iff (sys_rst)
    $past(sys_rst) |-> {st_ff.master, st_ff.addr} ==
    $past({strap_master, strap_addr}))
    else $error("role or address strap not taken");

  // strap pins are ignored once running, only reset reloads them
  straps_held_a: assert property (@(posedge mclk)
    disable iff (sys_rst)
    !$past(sys_rst) |-> $stable(st_ff.spd) && $stable(st_ff.master) &&
    $stable(st_ff.addr)) else $error("straps changed while running");

  // loopback never puts mac data on the wire
  loop_quiet_a: assert property (@(posedge mclk)
    disable iff (sys_rst)
    loop_on |=> !line_tx_en) else $error("wire active in loopback");
  loop_data_a: assert property (@(posedge mclk)
    disable iff (sys_rst)
    loop_on |=> rxd == $past(st_ff.txd_c))
    else $error("loopback data differs");

  // generator owns the line while enabled and loopback is off
  gen_busy_a: assert property (@(posedge mclk)
    disable iff (sys_rst)
    gen_on && !loop_on |=> line_tx_en == $past(st_ff.gbusy))
    else $error("generator enable wrong");
  gen_stop_a: assert property (@(posedge mclk)
    disable iff (sys_rst)
    !(gen_on && link_ok) |=> !st_ff.gbusy)
    else $error("generator runs while off");
  gen_len_a: assert property (@(posedge mclk)
    disable iff (sys_rst)
    gen_on && link_ok && st_ff.gbusy && st_ff.gcnt == GEN_LEN
    |=> !st_ff.gbusy) else $error("generator packet too long");

  // capture edges: own clock below gigabit, mac clock at gigabit
  capture_gig_a: assert property (@(posedge mclk)
    disable iff (sys_rst)
    gig && gtx_rise |=> st_ff.txd_c == $past(txd))
    else $error("gigabit capture missed");
  capture_mii_a: assert property (@(posedge mclk)
    disable iff (sys_rst)
    !gig && mii_rise |=> st_ff.tx_en_c == $past(tx_en))
    else $error("mii capture missed");
  no_capture_a: assert property (@(posedge mclk)
    disable iff (sys_rst)
    !cap |=> $stable(st_ff.txd_c)) else $error("capture off edge");

  // the divider rests at gigabit so nothing leaks onto tx_clk
  mii_rest_a: assert property (@(posedge mclk)
    disable iff (sys_rst)
    gig |-> !mii_clk) else $error("mii clock runs at gigabit");

  // at 100 the divider is limited to one system cycle per half
  mii_fast_a: assert property (@(posedge mclk)
    disable iff (sys_rst)
    st_ff.spd == SPD_100 && $rose(mii_clk) |=> !mii_clk)
    else $error("100 mb clock rate");

  // errored or missing line data leaves the indicator dark
  activity_bad_a: assert property (@(posedge mclk)
    disable iff (sys_rst)
    line_rx_err |=> !activity) else $error("activity on error");
  idle_rx_a: assert property (@(posedge mclk)
    disable iff (sys_rst)
    !loop_on && !link_ok |=> !rx_dv) else $error("receive without link");

  // test pin quiet unless a jitter mode or the enable bit asks
  test_clk_off_a: assert property (@(posedge mclk)
    disable iff (sys_rst)
    tmode != TMODE_2 && tmode != TMODE_3 && !tmode_out
    |-> !line_transmit_test_clock) else $error("test clock stray");
  test_clk_on_a: assert property (@(posedge mclk)
    disable iff (sys_rst)
    gig && tmode == TMODE_2 |-> line_transmit_test_clock ==
    (st_ff.master ? ref_line_clk : rec_line_clk))
    else $error("test clock not the line clock");
endmodule

// ==== tb/mgmt_master.sv ====
// management master model driving the serial management pins
`timescale 1ns/1ps
module mgmt_master (
  // clock
  input wire logic mclk,
  // management pins
  output logic mdc,
  output logic mdio_in,
  input wire logic mdio_out,
  input wire logic mdio_oe
);
  import phy_clk_pkg::*;
  logic drv;
  logic bit_v;
  // pull-up wins when nobody drives the line
  assign mdio_in = mdio_oe ? mdio_out : (drv ? bit_v : 1'b1);
  initial begin
    mdc = 1'b0;
    drv = 1'b0;
    bit_v = 1'b1;
  end
  // one bit: 9 mclk period gives about 1.11 MHz, under the ceiling
  task automatic send(input logic d, input logic own, output logic s);
    @(posedge mclk);
    mdc <= 1'b0;
    drv <= own;
    bit_v <= d;
    repeat (4) @(posedge mclk);
    mdc <= 1'b1;
    repeat (4) @(posedge mclk);
    s = mdio_in;
  endtask
  // whole frame, read data sampled late in each bit
  task automatic frame(input logic [1:0] op, input logic [4:0] pa,
    input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
    logic s;
    logic [13:0] hdr;
    int i;
    hdr = {2'b01, op, pa, ra};
    for (i = 0; i < 32; i++) send(1'b1, 1'b1, s);
    for (i = 13; i >= 0; i--) send(hdr[i], 1'b1, s);
    if (op == OP_WRITE) begin
      send(1'b1, 1'b1, s);
      send(1'b0, 1'b1, s);
    end else begin
      // release both turnaround bits so the slave may take over
      send(1'b1, 1'b0, s);
      send(1'b1, 1'b0, s);
    end
    for (i = 15; i >= 0; i--) begin
      send(wd[i], op == OP_WRITE, s);
      rd[i] = s;
    end
    @(posedge mclk);
    drv <= 1'b0;
  endtask
endmodule

// ==== tb/phy_mac_side_clocking_test.sv ====
// self-checking bench for the mac-side clocking block
`timescale 1ns/1ps
module phy_mac_side_clocking_test;
  import phy_clk_pkg::*;
  logic mclk = 1'b0, sys_rst = 1'b1, strap_master = 1'b0;
  speed_t strap_speed = SPD_10;
  logic [4:0] strap_addr = 5'h03;
  logic link_ok = 1'b1, ref_line_clk = 1'b0, rec_line_clk = 1'b0;
  logic line_rx_dv = 1'b0, line_rx_err = 1'b0, gtx_clk = 1'b0;
  logic tx_en = 1'b0;
  logic [7:0] line_rxd = 8'h00, txd = 8'h00, rxd, line_txd;
  logic tx_clk, rx_clk, rx_dv, line_tx_en, line_tx_clk_sel;
  logic line_transmit_test_clock, activity, mdc, mdio_in;
  logic mdio_out, mdio_oe;
  logic [15:0] rd;
  int err_count = 0, tests_run = 0;
  always #50 mclk = ~mclk;
  // line and gigabit clocks; recovered runs at half the reference rate
  always @(posedge mclk) begin
    ref_line_clk <= ~ref_line_clk;
    gtx_clk <= ~gtx_clk;
    if (ref_line_clk) rec_line_clk <= ~rec_line_clk;
  end
  phy_mac_side_clocking uut (.mclk(mclk), .sys_rst(sys_rst),
    .strap_speed(strap_speed), .strap_master(strap_master),
    .strap_addr(strap_addr), .link_ok(link_ok),
    .ref_line_clk(ref_line_clk), .rec_line_clk(rec_line_clk),
    .line_rx_dv(line_rx_dv), .line_rx_err(line_rx_err),
    .line_rxd(line_rxd), .gtx_clk(gtx_clk), .tx_en(tx_en), .txd(txd),
    .tx_clk(tx_clk), .rx_clk(rx_clk), .rx_dv(rx_dv), .rxd(rxd),
    .line_tx_en(line_tx_en), .line_txd(line_txd),
    .line_tx_clk_sel(line_tx_clk_sel),
    .line_transmit_test_clock(line_transmit_test_clock),
    .activity(activity), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe));
  mgmt_master mm (.mclk(mclk), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe));
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  // straps change only under reset, which is held four cycles
  task automatic do_reset(input speed_t s, input logic m);
    @(posedge mclk);
    sys_rst <= 1'b1;
    strap_speed <= s;
    strap_master <= m;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
  endtask
  // bounded wait on rx_dv (0), line_tx_en (1) or activity (2)
  task automatic wait_hi(input string n, input int sel);
    int i;
    for (i = 0; i < 200; i++) begin
      @(negedge mclk);
      if ((sel == 0 ? rx_dv : sel == 1 ? line_tx_en : activity) === 1'b1)
        return;
    end
    chk(n, 16'h0001, 16'h0000);
    conclude();
  endtask
  // rising edges of tx_clk (0) or the test clock (1) over c cycles
  task automatic rises(input int sel, input int c, output int n);
    logic p, v;
    int i;
    n = 0;
    // a clock already high at the window start counts as its rise
    p = 1'b0;
    for (i = 0; i < c; i++) begin
      @(negedge mclk);
      v = sel == 0 ? tx_clk : line_transmit_test_clock;
      if (v === 1'b1 && p === 1'b0) n++;
      p = v;
    end
  endtask
  task automatic t_gig;
    int n;
    do_reset(SPD_1000, 1'b1);
    chk("clk_sel", 16'h0001, {15'h0000, line_tx_clk_sel});
    rises(0, 20, n);
    chk("tx_clk_rises", 16'h0000, 16'(n));
    chk("tx_clk", 16'h0000, {15'h0000, tx_clk});
    mm.frame(OP_READ, strap_addr, REG_CTRL, 16'h0000, rd);
    chk("ctrl_reset", CTRL_RST, rd);
    mm.frame(OP_READ, strap_addr, 5'h01, 16'h0000, rd);
    chk("status", 16'h0007, rd);
    // a foreign address must leave the line to the pull-up
    mm.frame(OP_READ, 5'h04, REG_CTRL, 16'h0000, rd);
    chk("foreign_read", 16'hFFFF, rd);
  endtask
  task automatic t_loop;
    mm.frame(OP_WRITE, strap_addr, REG_CTRL, 16'h4000, rd);
    mm.frame(OP_READ, strap_addr, REG_CTRL, 16'h0000, rd);
    chk("ctrl_back", 16'h4000, rd);
    @(posedge mclk);
    tx_en <= 1'b1;
    txd <= 8'hA5;
    wait_hi("loop_dv", 0);
    chk("loop_rxd", 16'h00A5, {8'h00, rxd});
    @(posedge mclk);
    tx_en <= 1'b0;
    mm.frame(OP_WRITE, strap_addr, REG_CTRL, 16'h0000, rd);
  endtask
  task automatic t_gen(input logic [2:0] mode);
    int n;
    logic [15:0] v;
    v = 16'h0001 | (16'(mode) << TEST_MODE_LSB);
    mm.frame(OP_WRITE, strap_addr, REG_TEST, v, rd);
    wait_hi("gen_tx_en", 1);
    rises(1, 16, n);
    chk("test_clk_runs", 16'h0001, 16'(n > 0));
    mm.frame(OP_WRITE, strap_addr, REG_TEST, TEST_RST, rd);
  endtask
  // no management traffic at all: straps alone set the speed
  task automatic t_mii(input speed_t s, input int half);
    int n;
    do_reset(s, 1'b0);
    rises(0, 40, n);
    chk("mii_rises", 16'(40 / (2 * half)), 16'(n));
    @(posedge mclk);
    line_rxd <= 8'hFF;
    line_rx_dv <= 1'b1;
    wait_hi("activity", 2);
    wait_hi("rx_dv", 0);
    chk("rxd_upper", 16'h0000, {12'h000, rxd[7:4]});
    @(posedge mclk);
    line_rx_dv <= 1'b0;
  endtask
  initial begin
    t_gig();
    t_loop();
    t_gen(TMODE_2);
    t_gen(TMODE_3);
    t_mii(SPD_10, HALF10_CYC);
    t_mii(SPD_100, HALF100_CYC);
    conclude();
  end
endmodule
